// [logic/sst_pkg.sv]
package sst_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FRAME_CTRL = 8'h15;
    localparam logic [7:0] IDX_ENABLE = 8'h16;
    localparam logic [7:0] IDX_STATUS = 8'h17;
    localparam logic [7:0] IDX_DATA = 8'h18;
    localparam logic [7:0] FRAME_CTRL_RST = 8'h00;
    // Frame control fields
    localparam int RX8_BIT = 7;
    localparam int TX8_BIT = 6;
    localparam int CLK_PIN_SELECT_BIT = 5;
    localparam int WLEN_BIT = 4;
    localparam int WAKE_BIT = 3;
    localparam int CLK_IDLE_LEVEL_BIT = 2;
    localparam int CLK_PHASE_SEL_BIT = 1;
    localparam int FINAL_BIT_CLK_EN_BIT = 0;
    // Enable control and status fields
    localparam int TXEN_BIT = 3;
    localparam int SLEEP_BIT = 1;
    localparam int ST_EMPTY_BIT = 7;
    localparam int ST_IDLE_BIT = 6;
    localparam int ST_FULL_BIT = 5;
    // Bit timing in sample ticks and frame counts
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] TICK_HALF = 4'h8;
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] DATA_BITS_9 = 4'h9;
    localparam logic [3:0] PRE_BITS_8 = 4'ha;
    localparam logic [3:0] PRE_BITS_9 = 4'hb;
    typedef enum logic [2:0] {
        TX_IDLE, TX_PRE, TX_START, TX_DATA, TX_STOP
    } sst_tx_t;
    typedef enum logic [1:0] {
        RX_IDLE, RX_START, RX_DATA, RX_STOP
    } sst_rx_t;
endpackage

// [logic/sst_top.sv]
`timescale 1ns/1ps
module sst_top
    import sst_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESETN_I,
    // Avalon-MM slave
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // Sample clock and serial pins
    input wire logic RT_CLK_I,
    input wire logic RXD_I,
    output logic TXD_O,
    output logic TXD_OE_O,
    output logic SCK_O,
    output logic SCK_OE_O
);
    typedef struct packed {
        logic [1:0] rt_sync;
        logic rt_prev;
        logic [1:0] rxd_sync;
        logic ack;
        logic [7:0] rdata;
        logic [7:0] ctrl;
        logic tx_en;
        logic tx_en_prev;
        logic pre_pend;
        logic sleep;
        logic [7:0] thr;
        logic thr_full;
        sst_tx_t tst;
        logic [3:0] tph;
        logic [3:0] tbit;
        logic [8:0] tsh;
        logic tdo;
        logic sck;
        sst_rx_t rst;
        logic [3:0] rph;
        logic [3:0] rbit;
        logic [8:0] rsh;
        logic [3:0] ones;
        logic [7:0] rhr;
        logic rx_full;
    } sst_state_t;

    sst_state_t state_reg;
    sst_state_t state_next;

    function automatic logic [7:0] reg_index(input logic [7:0] a);
        reg_index = (a[1:0] == 2'b00) ? {2'b00, a[7:2]} : 8'hff;
    endfunction

    logic tick;
    logic rxd;
    logic tbnd;
    logic wlen;
    logic [3:0] ndat;
    logic [3:0] npre;
    logic clocked;
    logic half;
    logic [7:0] idx;
    logic tx_active;

    assign tick = state_reg.rt_sync[1] & ~state_reg.rt_prev;
    assign rxd = state_reg.rxd_sync[1];
    assign tbnd = tick && (state_reg.tph == TICK_LAST);
    assign wlen = state_reg.ctrl[WLEN_BIT];
    assign ndat = wlen ? DATA_BITS_9 : DATA_BITS_8;
    assign npre = wlen ? PRE_BITS_9 : PRE_BITS_8;
    assign idx = reg_index(AVS_ADDRESS_I);
    assign tx_active = state_reg.tx_en || (state_reg.tst != TX_IDLE);

    // Last data bit gets a pulse only with final_bit_clk_en set
    assign clocked = (state_reg.tst == TX_DATA) &&
        ((state_reg.tbit != ndat - 4'h1) ||
         state_reg.ctrl[FINAL_BIT_CLK_EN_BIT]);
    assign half = state_reg.ctrl[CLK_PHASE_SEL_BIT] ?
        (state_reg.tph < TICK_HALF) :
        (state_reg.tph >= TICK_HALF);

    always_comb begin
        state_next = state_reg;
        state_next.rt_sync = {state_reg.rt_sync[0], RT_CLK_I};
        state_next.rt_prev = state_reg.rt_sync[1];
        state_next.rxd_sync = {state_reg.rxd_sync[0], RXD_I};
        state_next.tx_en_prev = state_reg.tx_en;

        // Bus: answer one cycle after the request is seen
        state_next.ack = (AVS_READ_I || AVS_WRITE_I) && !state_reg.ack;
        if (AVS_READ_I && !state_reg.ack) begin
            case (idx)
                IDX_FRAME_CTRL: state_next.rdata = state_reg.ctrl;
                IDX_ENABLE: state_next.rdata =
                    8'({state_reg.tx_en, 2'b00, state_reg.sleep, 1'b0});
                IDX_STATUS: state_next.rdata = 8'({!state_reg.thr_full,
                    !tx_active, state_reg.rx_full, 5'h00});
                IDX_DATA: state_next.rdata = state_reg.rhr;
                default: state_next.rdata = 8'h00;
            endcase
        end
        if (AVS_READ_I && state_reg.ack && idx == IDX_DATA) begin
            state_next.rx_full = 1'b0;
        end
        if (AVS_WRITE_I && state_reg.ack && AVS_BYTEENABLE_I[0]) begin
            case (idx)
                IDX_FRAME_CTRL: state_next.ctrl[6:0] = AVS_WRITEDATA_I[6:0];
                IDX_ENABLE: begin
                    state_next.tx_en = AVS_WRITEDATA_I[TXEN_BIT];
                    if (AVS_WRITEDATA_I[SLEEP_BIT]) begin
                        state_next.sleep = 1'b1;
                    end
                end
                IDX_DATA: begin
                    state_next.thr = AVS_WRITEDATA_I[7:0];
                    state_next.thr_full = 1'b1;
                end
                default: state_next.thr = state_reg.thr;
            endcase
        end

        // Preamble request on a rising enable
        if (state_reg.tx_en && !state_reg.tx_en_prev) begin
            state_next.pre_pend = 1'b1;
        end

        // Transmitter: bit time of sixteen sample ticks
        if (tick) begin
            state_next.tph = state_reg.tph + 4'h1;
        end
        if (tbnd) begin
            case (state_reg.tst)
                TX_IDLE: begin
                    state_next.tdo = 1'b1;
                    if (state_reg.pre_pend) begin
                        state_next.pre_pend = 1'b0;
                        state_next.tst = TX_PRE;
                        state_next.tbit = 4'h0;
                    end else if (state_reg.tx_en &&
                                 state_reg.thr_full) begin
                        state_next.tsh = {state_reg.ctrl[TX8_BIT],
                            state_reg.thr};
                        state_next.thr_full = state_reg.ack && AVS_WRITE_I &&
                            AVS_BYTEENABLE_I[0] && idx == IDX_DATA;
                        state_next.tst = TX_START;
                        state_next.tdo = 1'b0;
                    end
                end
                TX_PRE: begin
                    state_next.tbit = state_reg.tbit + 4'h1;
                    if (state_reg.tbit == npre - 4'h1) begin
                        state_next.tst = TX_IDLE;
                    end
                end
                TX_START: begin
                    state_next.tst = TX_DATA;
                    state_next.tbit = 4'h0;
                    state_next.tdo = state_reg.tsh[0];
                end
                TX_DATA: begin
                    if (state_reg.tbit == ndat - 4'h1) begin
                        state_next.tst = TX_STOP;
                        state_next.tdo = 1'b1;
                    end else begin
                        state_next.tbit = state_reg.tbit + 4'h1;
                        state_next.tsh = {1'b0, state_reg.tsh[8:1]};
                        state_next.tdo = state_reg.tsh[1];
                    end
                end
                TX_STOP: begin
                    state_next.tst = TX_IDLE;
                end
                default: state_next.tst = TX_IDLE;
            endcase
        end
        // Clock rests at clk_idle_level, toggles half a bit per clocked data bit
        state_next.sck = state_reg.ctrl[CLK_IDLE_LEVEL_BIT] ^
            (clocked && half);

        // Receiver: own timing from start edge, uses word length and wake options
        if (tick) begin
            state_next.rph = state_reg.rph + 4'h1;
            case (state_reg.rst)
                RX_IDLE: begin
                    if (!rxd) begin
                        state_next.rst = RX_START;
                        state_next.rph = 4'h0;
                        state_next.ones = 4'h0;
                    end else if (state_reg.rph == TICK_LAST &&
                                 state_reg.ones != npre) begin
                        state_next.ones = state_reg.ones + 4'h1;
                        if (state_reg.ones == npre - 4'h1 &&
                            state_reg.sleep &&
                            !state_reg.ctrl[WAKE_BIT]) begin
                            state_next.sleep = 1'b0;
                        end
                    end
                end
                RX_START: begin
                    if (state_reg.rph == TICK_MID && rxd) begin
                        state_next.rst = RX_IDLE;
                    end else if (state_reg.rph == TICK_LAST) begin
                        state_next.rst = RX_DATA;
                        state_next.rbit = 4'h0;
                    end
                end
                RX_DATA: begin
                    if (state_reg.rph == TICK_MID) begin
                        state_next.rsh = {rxd, state_reg.rsh[8:1]};
                    end
                    if (state_reg.rph == TICK_LAST) begin
                        state_next.rbit = state_reg.rbit + 4'h1;
                        if (state_reg.rbit == ndat - 4'h1) begin
                            state_next.rst = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (state_reg.rph == TICK_MID) begin
                        state_next.rst = RX_IDLE;
                        state_next.rph = 4'h0;
                        // MSB of the word sits in rsh[8] in both modes
                        if (!state_reg.sleep || (state_reg.ctrl[WAKE_BIT]
                            && state_reg.rsh[8])) begin
                            state_next.sleep = 1'b0;
                            state_next.rx_full = 1'b1;
                            state_next.rhr = wlen ? state_reg.rsh[7:0] :
                                state_reg.rsh[8:1];
                            state_next.ctrl[RX8_BIT] =
                                state_reg.rsh[8];
                        end
                    end
                end
                default: state_next.rst = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_reg <= '0;
            state_reg.ctrl <= FRAME_CTRL_RST;
            state_reg.rsh <= 9'h1ff;
            state_reg.tdo <= 1'b1;
            state_reg.rxd_sync <= 2'b11;
            state_reg.tst <= TX_IDLE;
            state_reg.rst <= RX_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) &&
        !state_reg.ack;
    assign AVS_READDATA_O = {24'h000000, state_reg.rdata};
    assign TXD_O = state_reg.tdo;
    assign TXD_OE_O = tx_active;
    assign SCK_O = state_reg.sck;
    assign SCK_OE_O = state_reg.ctrl[CLK_PIN_SELECT_BIT] && tx_active;

    sequence s_start_end;
        state_reg.tst == TX_START && tbnd;
    endsequence
    sequence s_load;
        tbnd && state_reg.tst == TX_IDLE && !state_reg.pre_pend &&
        state_reg.tx_en && state_reg.thr_full;
    endsequence

    a_tick_count: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I) tick |=>
        state_reg.tph == 4'($past(state_reg.tph) + 4'h1))
        else $error("tick phase did not advance");
    a_clk_rest: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I) $past(state_reg.tst) != TX_DATA |->
        SCK_O == $past(state_reg.ctrl[CLK_IDLE_LEVEL_BIT]))
        else $error("clock left rest level outside data");
    a_phase_edge: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I)
        $past(clocked && state_reg.tph == 4'h0) |->
        SCK_O == ($past(state_reg.ctrl[CLK_IDLE_LEVEL_BIT]) ^
        $past(state_reg.ctrl[CLK_PHASE_SEL_BIT])))
        else $error("clock phase wrong at bit start");
    a_last_pulse: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I) $past(state_reg.tst == TX_DATA &&
        state_reg.tbit == ndat - 4'h1 && !state_reg.ctrl[FINAL_BIT_CLK_EN_BIT]) |->
        SCK_O == $past(state_reg.ctrl[CLK_IDLE_LEVEL_BIT]))
        else $error("last bit clocked while disabled");
    a_shift_load: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I) s_load |=> state_reg.tst == TX_START &&
        state_reg.tsh == {$past(state_reg.ctrl[TX8_BIT]),
        $past(state_reg.thr)} && !TXD_O)
        else $error("holding word not moved to shifter");
    a_lsb_first: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I) s_start_end |=>
        TXD_O == $past(state_reg.tsh[0]) && state_reg.tst == TX_DATA)
        else $error("first data bit not the lsb");
    a_rx8_ro: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I) state_reg.rst != RX_STOP |=>
        state_reg.ctrl[RX8_BIT] == $past(state_reg.ctrl[RX8_BIT]))
        else $error("rx ninth bit changed outside capture");
    a_sleep_gate: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I) (state_reg.sleep &&
        !state_reg.ctrl[WAKE_BIT] && state_reg.rst == RX_STOP) |=>
        $stable(state_reg.rhr))
        else $error("sleeping receiver loaded a word");
    a_pre_start: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I) $rose(state_reg.tx_en) |=>
        state_reg.pre_pend)
        else $error("preamble not requested on enable");
    a_bus_answer: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I) AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("bus answer later than one cycle");
endmodule

// [tb/sst_peer.sv]
`timescale 1ns/1ps
module sst_peer (
    // Sample clock and receive line
    output logic rt_o,
    output logic rxd_o,
    // Transmit side under watch
    input wire logic txd_i,
    input wire logic sck_i,
    input wire logic clk_idle_level_i,
    input wire logic nine_i
);
    int ticks = 0;
    int t0 = 0;
    int pulses = 0;
    int first_tick = 0;
    logic in_frame = 1'b0;
    logic idle_ok = 1'b0;
    logic [8:0] word = 9'h000;
    event got;
    initial begin
        rt_o = 1'b0;
        rxd_o = 1'b1;
    end
    // Sample clock runs free, as the receiver needs it between frames
    always #100 rt_o = ~rt_o;
    always @(posedge rt_o) ticks <= ticks + 1;
    // Decode a frame at mid-bit, sixteen ticks a bit
    always begin
        @(negedge txd_i);
        t0 = ticks;
        pulses = 0;
        first_tick = -1;
        word = 9'h000;
        in_frame = 1'b1;
        repeat (8) @(posedge rt_o);
        idle_ok = (sck_i === clk_idle_level_i) && (txd_i === 1'b0);
        for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
            repeat (16) @(posedge rt_o);
            word[i] = txd_i;
        end
        repeat (16) @(posedge rt_o);
        idle_ok = idle_ok && (sck_i === clk_idle_level_i) && (txd_i === 1'b1);
        in_frame = 1'b0;
        ->got;
    end
    // Count departures of the clock from its resting level
    always @(sck_i) begin
        if (in_frame && sck_i !== clk_idle_level_i) begin
            if (first_tick < 0) first_tick = ticks - t0;
            pulses++;
        end
    end
    // Line idles high; start, data LSB first, stop
    task automatic send(input logic [8:0] w, input logic nine);
        rxd_o = 1'b0;
        repeat (16) @(posedge rt_o);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            rxd_o = w[i];
            repeat (16) @(posedge rt_o);
        end
        rxd_o = 1'b1;
        repeat (40) @(posedge rt_o);
    endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top
    import sst_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wreq, rt, rxd, txd, txd_oe, sck, sck_oe;
    logic clk_idle_level = 1'b0;
    logic nine = 1'b0;
    logic [7:0] fc, q;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int t_en = 0;
    int gap = 0;
    sst_top dut (
        .SYS_CLK_I(clk), .RESETN_I(rstn), .AVS_ADDRESS_I(addr),
        .AVS_BYTEENABLE_I(4'h1), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wreq), .RT_CLK_I(rt), .RXD_I(rxd),
        .TXD_O(txd), .TXD_OE_O(txd_oe), .SCK_O(sck), .SCK_OE_O(sck_oe)
    );
    sst_peer peer (
        .rt_o(rt), .rxd_o(rxd), .txd_i(txd), .sck_i(sck),
        .clk_idle_level_i(clk_idle_level), .nine_i(nine)
    );
    always #12.5 clk = ~clk;
    task automatic tally_and_finish;
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles > 60000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    task automatic check(input string what, input logic [8:0] got,
                         input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Hold the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] d);
        @(posedge clk);
        addr <= {idx[5:0], 2'b00};
        rd <= ~w;
        wr <= w;
        wdata <= {24'h0, d};
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] idx,
                          input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(what, 9'(q), 9'(exp));
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_chk("fctrl reset", IDX_FRAME_CTRL, FRAME_CTRL_RST);
        rd_chk("unmapped", 8'h1f, 8'h00);
        bus(1'b1, IDX_FRAME_CTRL, 8'hc0);
        rd_chk("ninth bits", IDX_FRAME_CTRL, 8'h40);
        for (int i = 0; i < 4; i++) begin
            // Options change only while the transmitter is off
            fc = {3'b011, i[1], 1'b0, i[0], i[1], i[0]};
            bus(1'b1, IDX_FRAME_CTRL, fc);
            clk_idle_level = fc[CLK_IDLE_LEVEL_BIT];
            nine = fc[WLEN_BIT];
            repeat (4) @(posedge clk);
            check("sck rest", 9'(sck), 9'(clk_idle_level));
            check("sck oe idle", 9'(sck_oe), 9'h0);
            bus(1'b1, IDX_ENABLE, 8'h08);
            t_en = peer.ticks;
            bus(1'b1, IDX_DATA, 8'h5a ^ 8'(i));
            check("sck oe on", 9'(sck_oe), 9'h1);
            @(peer.got);
            check("word", peer.word,
                  nine ? {1'b1, 8'h5a ^ 8'(i)} : 9'(8'h5a ^ 8'(i)));
            check("pulses", 9'(peer.pulses), 9'(7 + i[1] + i[0]));
            check("first edge", 9'(peer.first_tick),
                  fc[CLK_PHASE_SEL_BIT] ? 9'd16 : 9'd24);
            check("sck quiet", 9'(peer.idle_ok), 9'h1);
            gap = peer.t0 - t_en - (nine ? 16 : 0);
            // Preamble plus one idle bit, up to one bit of boundary wait
            check("preamble", 9'(gap >= 176 && gap <= 192), 9'h1);
            bus(1'b1, IDX_ENABLE, 8'h00);
            do @(posedge clk); while (txd_oe !== 1'b0);
            check("sck oe off", 9'(sck_oe), 9'h0);
        end
        bus(1'b1, IDX_FRAME_CTRL, 8'h06);
        peer.send(9'h0a5, 1'b0);
        bus(1'b0, IDX_STATUS, 8'h00);
        check("full", 9'(q[ST_FULL_BIT]), 9'h1);
        rd_chk("rx data", IDX_DATA, 8'ha5);
        bus(1'b1, IDX_FRAME_CTRL, 8'h10);
        peer.send(9'h13c, 1'b1);
        bus(1'b0, IDX_FRAME_CTRL, 8'h00);
        check("rx ninth", 9'(q[RX8_BIT]), 9'h1);
        rd_chk("rx data 9", IDX_DATA, 8'h3c);
        bus(1'b1, IDX_FRAME_CTRL, 8'h18);
        bus(1'b1, IDX_ENABLE, 8'h02);
        peer.send(9'h055, 1'b1);
        bus(1'b0, IDX_STATUS, 8'h00);
        check("asleep full", 9'(q[ST_FULL_BIT]), 9'h0);
        rd_chk("still asleep", IDX_ENABLE, 8'h02);
        peer.send(9'h1aa, 1'b1);
        bus(1'b0, IDX_STATUS, 8'h00);
        check("woken full", 9'(q[ST_FULL_BIT]), 9'h1);
        rd_chk("woken", IDX_ENABLE, 8'h00);
        rd_chk("addr word", IDX_DATA, 8'haa);
        // Idle-line wake: a word while asleep is dropped, then idle wakes
        bus(1'b1, IDX_FRAME_CTRL, 8'h10);
        bus(1'b1, IDX_ENABLE, 8'h02);
        peer.send(9'h033, 1'b1);
        bus(1'b0, IDX_STATUS, 8'h00);
        check("idle asleep", 9'(q[ST_FULL_BIT]), 9'h0);
        rd_chk("idle still", IDX_ENABLE, 8'h02);
        repeat (1600) @(posedge clk);
        rd_chk("idle woken", IDX_ENABLE, 8'h00);
        peer.send(9'h1c3, 1'b1);
        bus(1'b0, IDX_STATUS, 8'h00);
        check("idle full", 9'(q[ST_FULL_BIT]), 9'h1);
        rd_chk("idle data", IDX_DATA, 8'hc3);
        tally_and_finish;
    end
endmodule
